// file: design/cal_pkg.sv
// Purpose: Shared constants and types for the capacity alert and load model block
// Assumes: One measurement update per second from the measurement engine
// Notes:   Register offsets are byte addresses on a 32-bit Avalon-MM slave
package cal_pkg;

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_RCA_THR  = 8'h04;
  localparam logic [7:0] ADR_TDA_PCT  = 8'h08;
  localparam logic [7:0] ADR_CUR_THR  = 8'h0C;
  localparam logic [7:0] ADR_DESIGN   = 8'h10;
  localparam logic [7:0] ADR_USR_RATE = 8'h14;
  localparam logic [7:0] ADR_HOST     = 8'h18;
  localparam logic [7:0] ADR_RESERVE  = 8'h1C;
  localparam logic [7:0] ADR_CELL     = 8'h20;
  localparam logic [7:0] ADR_STATUS   = 8'h24;
  localparam logic [7:0] ADR_CAP      = 8'h28;
  localparam logic [7:0] ADR_ENERGY   = 8'h2C;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h30;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h34;

  // Reset values
  localparam logic [7:0]  LOAD_SEL_RST   = 8'h01;
  localparam logic [7:0]  LOAD_MODE_RST  = 8'h00;
  localparam logic [15:0] RCA_THR_RST    = 16'h0064;  // 100 mAh
  localparam logic [7:0]  DISCHARGE_ALERT_SET_PCT_RST    = 8'h06;     // 6 %
  localparam logic [7:0]  TDA_CLR_RST    = 8'h08;     // 8 %
  localparam logic [15:0] DSG_THR_RST    = 16'h0064;  // 100 mA
  localparam logic [15:0] CHG_THR_RST    = 16'h0032;  // 50 mA
  localparam logic [15:0] DSG_CAP_RST    = 16'h05DC;  // 1500 mAh
  localparam logic [15:0] DSG_ENERGY_RST = 16'h15AE;  // mWh, plain default
  localparam logic [15:0] QMAX_RST       = 16'h05DC;  // 1500 mAh
  localparam logic [15:0] RA_RST         = 16'h00A0;  // 2^-10 ohm units

  // Encodings
  localparam logic [7:0] MODE_POWER  = 8'h01;
  localparam logic [7:0] PCT_DISABLE = 8'hFF;        // -1 %
  localparam logic [7:0] SOC_FULL    = 8'h64;        // 100 %

  // Status field positions
  localparam int ST_RCA = 0;
  localparam int ST_TDA = 1;
  localparam int ST_DSG = 2;
  localparam int ST_CHG = 3;
  localparam int ST_SOC = 8;

  // Interrupt bit positions
  localparam int IRQ_CAPACITY_ALERT_THRESHOLD = 0;
  localparam int IRQ_RCA_CLR = 1;
  localparam int IRQ_DISCHARGE_ALERT_SET_PCT = 2;
  localparam int IRQ_TDA_CLR = 3;

  // Timing and unit constants
  localparam logic [15:0] UPDATE_PERIOD_S = 16'h0001;
  localparam logic [15:0] FILT_TAU_S      = 16'h000E;  // 14 s
  localparam logic [15:0] FILT_DIV        = FILT_TAU_S / UPDATE_PERIOD_S;
  localparam logic [31:0] MAS_PER_MAH     = 32'h0000_0E10;  // 3600 mA*s
  localparam logic [31:0] UWS_PER_10MWH   = 32'h0225_5100;  // 36e6 uW*s
  localparam logic [31:0] UW_PER_MW       = 32'h0000_03E8;  // 1000
  localparam logic [15:0] C5_DIV          = 16'h0005;
  localparam logic [15:0] RATE_10MW       = 16'h000A;
  localparam int          RA_SHIFT        = 10;
  localparam int          HEAD_SHIFT      = 10;
  localparam logic [22:0] PCT_SCALE       = 23'h00_0064;  // 100
  localparam logic [4:0]  DIV_STEPS       = 5'h17;       // 23 quotient bits

  // Measurement set delivered with each update
  typedef struct packed {
    logic signed [15:0] current;
    logic        [15:0] voltage;
    logic signed [15:0] avg_current;
    logic signed [15:0] prev_avg_current;
    logic signed [15:0] cycle_avg_current;
    logic signed [15:0] prev_avg_power;
    logic signed [15:0] cycle_avg_power;
  } cal_meas_t;

endpackage : cal_pkg

// file: design/cal_div.sv
// Purpose: Sequential percentage divider, quot = num * 100 / den
// Assumes: start is a one-cycle pulse; starts while busy are ignored
// Notes:   One quotient bit per clock, done pulses after 23 steps
`timescale 1ns/1ns
module cal_div
  import cal_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [15:0] num_i,
  input  wire logic [15:0] den_i,
  output logic             done_o,
  output logic      [15:0] quot_o
);

  typedef struct packed {
    logic        busy;
    logic [4:0]  cnt;
    logic [16:0] rem;
    logic [22:0] dq;
    logic [15:0] den;
    logic        done;
    logic [15:0] quot;
  } cal_div_state_t;

  cal_div_state_t st_r;
  cal_div_state_t st_nxt;

  // Restoring division, dividend shifts out as quotient shifts in
  always_comb
  begin
    logic [16:0] sh;
    sh = {st_r.rem[15:0], st_r.dq[22]};
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (!st_r.busy && start_i)
    begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = DIV_STEPS;
      st_nxt.rem  = 17'h0_0000;
      st_nxt.dq   = 23'(num_i) * PCT_SCALE;
      st_nxt.den  = den_i;
    end
    else if (st_r.busy)
    begin
      if (sh >= {1'b0, st_r.den})
      begin
        st_nxt.rem = sh - {1'b0, st_r.den};
        st_nxt.dq  = {st_r.dq[21:0], 1'b1};
      end
      else
      begin
        st_nxt.rem = sh;
        st_nxt.dq  = {st_r.dq[21:0], 1'b0};
      end
      st_nxt.cnt = st_r.cnt - 5'h01;
      if (st_r.cnt == 5'h01)
      begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
        // Zero divisor reports zero; large quotients saturate
        if (st_r.den == 16'h0000)
          st_nxt.quot = 16'h0000;
        else if (st_nxt.dq[22:16] != 7'h00)
          st_nxt.quot = 16'hFFFF;
        else
          st_nxt.quot = st_nxt.dq[15:0];
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign done_o = st_r.done;
  assign quot_o = st_r.quot;

endmodule : cal_div

// file: design/cal_gauge.sv
// Purpose: Capacity alert flags, load model selection and charge counting
// Assumes: Measurement inputs come from logic on ref_clk_i, one update per second
// Notes:   Alert flags move only when the divider delivers a new charge level
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
module cal_gauge
  import cal_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        meas_valid_i,
  input  wire cal_meas_t   meas_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             remaining_capacity_alert_o,
  output logic             terminate_discharge_alert_o,
  output logic             dsg_flow_o,
  output logic             chg_flow_o,
  output logic      [7:0]  soc_o,
  output logic             irq_o
);

  typedef struct packed {
    logic               waitreq;
    logic        [31:0] rdata;
    logic        [7:0]  load_sel;
    logic        [7:0]  load_mode;
    logic        [15:0] capacity_alert_threshold;
    logic signed [7:0]  discharge_alert_set_pct;
    logic signed [7:0]  discharge_alert_clear_pct;
    logic        [15:0] dsg_thr;
    logic        [15:0] chg_thr;
    logic        [15:0] dsg_cap;
    logic        [15:0] dsg_energy;
    logic        [15:0] user_ma;
    logic        [15:0] user_mw;
    logic signed [15:0] host_rate_value;
    logic        [15:0] rsv_mah;
    logic        [15:0] rsv_mwh;
    logic        [15:0] qmax;
    logic        [15:0] ra;
    logic        [15:0] raw_cap;
    logic        [15:0] raw_energy;
    logic signed [31:0] q_acc;
    logic signed [47:0] e_acc;
    logic signed [15:0] filt;
    logic        [15:0] rate;
    logic        [15:0] fcc;
    logic        [15:0] rem;
    logic        [15:0] energy;
    logic        [7:0]  soc;
    logic               remaining_capacity_alert;
    logic               terminate_discharge_alert;
    logic               dsg_flow;
    logic               chg_flow;
    logic               pend;
    logic               div_go;
    logic        [3:0]  irq_stat;
    logic        [3:0]  irq_mask;
    logic               irq;
  } cal_state_t;

  cal_state_t  st_r;
  cal_state_t  st_nxt;
  logic        div_done;
  logic [15:0] div_quot;

  // Magnitude of a signed quantity
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction : mag

  // Saturate a wide unsigned value to 16 bits
  function automatic logic [15:0] sat(input logic [31:0] v);
    sat = (v > 32'h0000_FFFF) ? 16'hFFFF : v[15:0];
  endfunction : sat

  // Current times voltage in mW
  function automatic logic [15:0] pwr(input logic signed [15:0] i, input logic [15:0] v);
    pwr = sat(({16'h0000, mag(i)} * {16'h0000, v}) / UW_PER_MW);
  endfunction : pwr

  // Byte-enable merge of write data into a register image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++)
      merge[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
  endfunction : merge

  // Percentage divider for state of charge
  cal_div u_div (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (st_r.div_go),
    .num_i     (st_r.rem),
    .den_i     (st_r.fcc),
    .done_o    (div_done),
    .quot_o    (div_quot)
  );

  // Next-state logic for bus, measurement pipeline, flags and interrupts
  always_comb
  begin
    logic [31:0]        img;
    logic [31:0]        wimg;
    logic [31:0]        w1c;
    logic signed [31:0] q_sum;
    logic signed [31:0] q_del;
    logic signed [31:0] c_new;
    logic signed [47:0] e_sum;
    logic signed [47:0] e_del;
    logic signed [47:0] e_new;
    logic signed [15:0] f_n;
    logic [15:0]        drop;
    logic [31:0]        loss;
    logic signed [17:0] rem_s;
    logic [7:0]         soc_n;
    logic               rca_n;
    logic               tda_n;
    logic [3:0]         ev;
    img    = 32'h0000_0000;
    wimg   = 32'h0000_0000;
    w1c    = 32'h0000_0000;
    q_sum  = 32'sh0000_0000;
    q_del  = 32'sh0000_0000;
    c_new  = 32'sh0000_0000;
    e_sum  = 48'sh0000_0000_0000;
    e_del  = 48'sh0000_0000_0000;
    e_new  = 48'sh0000_0000_0000;
    f_n    = st_r.filt;
    drop   = 16'h0000;
    loss   = 32'h0000_0000;
    rem_s  = 18'sh0_0000;
    soc_n  = st_r.soc;
    rca_n  = st_r.remaining_capacity_alert;
    tda_n  = st_r.terminate_discharge_alert;
    ev     = 4'h0;
    st_nxt = st_r;
    st_nxt.div_go = 1'b0;
    st_nxt.pend   = 1'b0;

    // Register image at the addressed offset; unmapped reads as zero
    case (avs_address_i)
      ADR_CTRL:     img = {16'h0000, st_r.load_mode, st_r.load_sel};
      ADR_RCA_THR:  img = {16'h0000, st_r.capacity_alert_threshold};
      ADR_TDA_PCT:  img = {16'h0000, st_r.discharge_alert_clear_pct, st_r.discharge_alert_set_pct};
      ADR_CUR_THR:  img = {st_r.chg_thr, st_r.dsg_thr};
      ADR_DESIGN:   img = {st_r.dsg_energy, st_r.dsg_cap};
      ADR_USR_RATE: img = {st_r.user_mw, st_r.user_ma};
      ADR_HOST:     img = {16'h0000, st_r.host_rate_value};
      ADR_RESERVE:  img = {st_r.rsv_mwh, st_r.rsv_mah};
      ADR_CELL:     img = {st_r.ra, st_r.qmax};
      ADR_STATUS:   img = {16'h0000, st_r.soc, 4'h0, st_r.chg_flow, st_r.dsg_flow, st_r.terminate_discharge_alert, st_r.remaining_capacity_alert};
      ADR_CAP:      img = {st_r.fcc, st_r.rem};
      ADR_ENERGY:   img = {st_r.rate, st_r.energy};
      ADR_IRQ_STAT: img = {28'h000_0000, st_r.irq_stat};
      ADR_IRQ_MASK: img = {28'h000_0000, st_r.irq_mask};
      default:      img = 32'h0000_0000;
    endcase
    wimg = merge(img, avs_writedata_i, avs_byteenable_i);

    // Bus handshake: accept, drop waitrequest one cycle, then complete
    if ((avs_read_i || avs_write_i) && st_r.waitreq)
    begin
      st_nxt.waitreq = 1'b0;
      st_nxt.rdata   = avs_read_i ? img : st_r.rdata;
    end
    else
      st_nxt.waitreq = 1'b1;

    // Register writes take effect at the completing edge
    if (avs_write_i && !st_r.waitreq)
    begin
      case (avs_address_i)
        ADR_CTRL:
        begin
          st_nxt.load_sel  = wimg[7:0];
          st_nxt.load_mode = wimg[15:8];
        end
        ADR_RCA_THR:
          st_nxt.capacity_alert_threshold = wimg[15:0];
        ADR_TDA_PCT:
        begin
          st_nxt.discharge_alert_set_pct   = wimg[7:0];
          st_nxt.discharge_alert_clear_pct = wimg[15:8];
        end
        ADR_CUR_THR:
        begin
          st_nxt.dsg_thr = wimg[15:0];
          st_nxt.chg_thr = wimg[31:16];
        end
        ADR_DESIGN:
        begin
          st_nxt.dsg_cap    = wimg[15:0];
          st_nxt.dsg_energy = wimg[31:16];
        end
        ADR_USR_RATE:
        begin
          st_nxt.user_ma = wimg[15:0];
          st_nxt.user_mw = wimg[31:16];
        end
        ADR_HOST:
          st_nxt.host_rate_value = wimg[15:0];
        ADR_RESERVE:
        begin
          st_nxt.rsv_mah = wimg[15:0];
          st_nxt.rsv_mwh = wimg[31:16];
        end
        ADR_CELL:
        begin
          st_nxt.qmax = wimg[15:0];
          st_nxt.ra   = wimg[31:16];
        end
        ADR_CAP:
          st_nxt.raw_cap = wimg[15:0];       // Seeds the counted capacity
        ADR_ENERGY:
          st_nxt.raw_energy = wimg[15:0];    // Seeds the counted energy
        ADR_IRQ_MASK:
          st_nxt.irq_mask = wimg[3:0];
        ADR_IRQ_STAT:
          w1c = avs_writedata_i & {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
        default:
          w1c = 32'h0000_0000;               // Unmapped and read-only writes are ignored
      endcase
    end

    // Stage 0: count charge and energy, direction, filter and load rate
    if (meas_valid_i)
    begin
      q_sum = st_r.q_acc + 32'(meas_i.current);
      q_del = q_sum / $signed(MAS_PER_MAH);
      st_nxt.q_acc = q_sum - q_del * $signed(MAS_PER_MAH);
      c_new = $signed({16'h0000, st_r.raw_cap}) + q_del;
      if (c_new < 0)
        st_nxt.raw_cap = 16'h0000;
      else if (c_new > $signed({16'h0000, st_r.qmax}))
        st_nxt.raw_cap = st_r.qmax;
      else
        st_nxt.raw_cap = c_new[15:0];
      e_sum = st_r.e_acc + 48'(meas_i.current) * 48'($signed({1'b0, meas_i.voltage}));
      e_del = e_sum / $signed(48'(UWS_PER_10MWH));
      st_nxt.e_acc = e_sum - e_del * $signed(48'(UWS_PER_10MWH));
      e_new = $signed({32'h0000_0000, st_r.raw_energy}) + e_del;
      if (e_new < 0)
        st_nxt.raw_energy = 16'h0000;
      else if (e_new > 48'sh0000_0000_FFFF)
        st_nxt.raw_energy = 16'hFFFF;
      else
        st_nxt.raw_energy = e_new[15:0];
      st_nxt.dsg_flow = meas_i.avg_current[15] && (mag(meas_i.avg_current) > st_r.dsg_thr);
      st_nxt.chg_flow = !meas_i.avg_current[15] && (16'(meas_i.avg_current) > st_r.chg_thr);
      f_n = 16'(17'(st_r.filt) + (17'(meas_i.avg_current) - 17'(st_r.filt)) / $signed({1'b0, FILT_DIV}));
      st_nxt.filt = f_n;
      if (st_r.load_mode == MODE_POWER)
      begin
        case (st_r.load_sel)
          8'h00:   st_nxt.rate = mag(meas_i.prev_avg_power);
          8'h01:   st_nxt.rate = mag(meas_i.cycle_avg_power);
          8'h02:   st_nxt.rate = pwr(meas_i.avg_current, meas_i.voltage);
          8'h03:   st_nxt.rate = pwr(f_n, meas_i.voltage);
          8'h04:   st_nxt.rate = st_r.dsg_energy / C5_DIV;
          8'h05:   st_nxt.rate = sat({16'h0000, mag(st_r.host_rate_value)} * {16'h0000, RATE_10MW});
          8'h06:   st_nxt.rate = sat({16'h0000, st_r.user_mw} * {16'h0000, RATE_10MW});
          default: st_nxt.rate = mag(meas_i.cycle_avg_power);
        endcase
      end
      else
      begin
        case (st_r.load_sel)
          8'h00:   st_nxt.rate = mag(meas_i.prev_avg_current);
          8'h01:   st_nxt.rate = mag(meas_i.cycle_avg_current);
          8'h02:   st_nxt.rate = mag(meas_i.avg_current);
          8'h03:   st_nxt.rate = mag(f_n);
          8'h04:   st_nxt.rate = st_r.dsg_cap / C5_DIV;
          8'h05:   st_nxt.rate = mag(st_r.host_rate_value);
          8'h06:   st_nxt.rate = st_r.user_ma;
          default: st_nxt.rate = mag(meas_i.cycle_avg_current);
        endcase
      end
      st_nxt.pend = 1'b1;
    end

    // Stage 1: load-compensated capacities, then start the divider
    if (st_r.pend)
    begin
      drop = sat(({16'h0000, st_r.rate} * {16'h0000, st_r.ra}) >> RA_SHIFT);
      loss = ({16'h0000, st_r.qmax} * {16'h0000, drop}) >> HEAD_SHIFT;
      st_nxt.fcc = (loss >= {16'h0000, st_r.qmax}) ? 16'h0000 : st_r.qmax - loss[15:0];
      rem_s = $signed({2'b00, st_r.raw_cap}) - $signed({2'b00, st_r.qmax})
            + $signed({2'b00, st_nxt.fcc}) - $signed({2'b00, st_r.rsv_mah});
      st_nxt.rem = rem_s[17] ? 16'h0000 : rem_s[15:0];
      st_nxt.energy = (st_r.raw_energy > st_r.rsv_mwh) ?
                      st_r.raw_energy - st_r.rsv_mwh : 16'h0000;
      st_nxt.div_go = 1'b1;
    end

    // Stage 2: state of charge and alert flags on each finished update
    if (div_done)
    begin
      soc_n = (div_quot > 16'(SOC_FULL)) ? SOC_FULL : div_quot[7:0];
      if (st_r.rem < st_r.capacity_alert_threshold)
        rca_n = 1'b1;
      else if (st_r.rem > st_r.capacity_alert_threshold)
        rca_n = 1'b0;
      if (st_r.discharge_alert_set_pct != PCT_DISABLE)
      begin
        if ($signed({1'b0, soc_n}) < 9'(st_r.discharge_alert_set_pct))
          tda_n = 1'b1;
        else if (st_r.terminate_discharge_alert && ($signed({1'b0, soc_n}) > 9'(st_r.discharge_alert_clear_pct)))
          tda_n = 1'b0;
      end
      st_nxt.soc = soc_n;
      st_nxt.remaining_capacity_alert = rca_n;
      st_nxt.terminate_discharge_alert = tda_n;
    end

    // Sticky events; a new event wins over a same-cycle clear
    ev[IRQ_CAPACITY_ALERT_THRESHOLD] = rca_n && !st_r.remaining_capacity_alert;
    ev[IRQ_RCA_CLR] = !rca_n && st_r.remaining_capacity_alert;
    ev[IRQ_DISCHARGE_ALERT_SET_PCT] = tda_n && !st_r.terminate_discharge_alert;
    ev[IRQ_TDA_CLR] = !tda_n && st_r.terminate_discharge_alert;
    st_nxt.irq_stat = (st_r.irq_stat & ~w1c[3:0]) | ev;
    st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  // State register with documented reset values
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r                           <= '0;
      st_r.waitreq                   <= 1'b1;
      st_r.load_sel                  <= LOAD_SEL_RST;
      st_r.load_mode                 <= LOAD_MODE_RST;
      st_r.capacity_alert_threshold  <= RCA_THR_RST;
      st_r.discharge_alert_set_pct   <= DISCHARGE_ALERT_SET_PCT_RST;
      st_r.discharge_alert_clear_pct <= TDA_CLR_RST;
      st_r.dsg_thr                   <= DSG_THR_RST;
      st_r.chg_thr                   <= CHG_THR_RST;
      st_r.dsg_cap                   <= DSG_CAP_RST;
      st_r.dsg_energy                <= DSG_ENERGY_RST;
      st_r.qmax                      <= QMAX_RST;
      st_r.ra                        <= RA_RST;
      st_r.raw_cap                   <= QMAX_RST;
      st_r.raw_energy                <= DSG_ENERGY_RST;
      st_r.fcc                       <= QMAX_RST;
      st_r.rem                       <= QMAX_RST;
      st_r.energy                    <= DSG_ENERGY_RST;
      st_r.soc                       <= SOC_FULL;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from the state register
  assign avs_readdata_o              = st_r.rdata;
  assign avs_waitrequest_o           = st_r.waitreq;
  assign remaining_capacity_alert_o  = st_r.remaining_capacity_alert;
  assign terminate_discharge_alert_o = st_r.terminate_discharge_alert;
  assign dsg_flow_o                  = st_r.dsg_flow;
  assign chg_flow_o                  = st_r.chg_flow;
  assign soc_o                       = st_r.soc;
  assign irq_o                       = st_r.irq;

endmodule : cal_gauge

// file: verification/cal_gauge_sva.sv
// Purpose: Port assertions for cal_gauge
// Assumes: Current thresholds keep their reset values
// Notes:   Bound into every cal_gauge instance
`timescale 1ns/1ns
module cal_gauge_sva
  import cal_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        meas_valid_i,
  input wire cal_meas_t   meas_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        remaining_capacity_alert_o,
  input wire logic        terminate_discharge_alert_o,
  input wire logic        dsg_flow_o,
  input wire logic        chg_flow_o,
  input wire logic [7:0]  soc_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Request taken, then exactly one cycle of wait released
  sequence s_taken; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence s_answer; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  // Flag stage outputs are first seen changed 27 edges after the update edge
  sequence s_after_upd; $past(meas_valid_i, 27); endsequence
  property p_answer; s_taken |=> s_answer; endproperty
  property p_rdata; !(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o); endproperty
  property p_rca_hold; $changed(remaining_capacity_alert_o) |-> s_after_upd; endproperty
  property p_tda_hold; $changed(terminate_discharge_alert_o) |-> s_after_upd; endproperty
  property p_soc_hold; $changed(soc_o) |-> s_after_upd; endproperty
  property p_dsg; meas_valid_i |=> dsg_flow_o == ($past(meas_i.avg_current) < -16'sh0064); endproperty
  property p_chg; meas_valid_i |=> chg_flow_o == ($past(meas_i.avg_current) > 16'sh0032); endproperty
  property p_flow_hold; !meas_valid_i |=> $stable(dsg_flow_o) && $stable(chg_flow_o); endproperty
  a_answer: assert property (p_answer) else $error("bus answer is not one wait cycle");
  a_rdata: assert property (p_rdata) else $error("read data moved without a read");
  a_rca_hold: assert property (p_rca_hold) else $error("capacity alert moved off update");
  a_tda_hold: assert property (p_tda_hold) else $error("discharge alert moved off update");
  a_soc_hold: assert property (p_soc_hold) else $error("charge level moved off update");
  a_dsg: assert property (p_dsg) else $error("discharge flow wrong");
  a_chg: assert property (p_chg) else $error("charge flow wrong");
  a_flow_hold: assert property (p_flow_hold) else $error("flow moved off update");
endmodule : cal_gauge_sva
bind cal_gauge cal_gauge_sva u_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .meas_valid_i(meas_valid_i),
  .meas_i(meas_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .remaining_capacity_alert_o(remaining_capacity_alert_o),
  .terminate_discharge_alert_o(terminate_discharge_alert_o), .dsg_flow_o(dsg_flow_o),
  .chg_flow_o(chg_flow_o), .soc_o(soc_o));

// file: verification/cal_host_mdl.sv
// Purpose: Host processor model issuing register cycles
// Assumes: Avalon-MM slave with waitrequest
// Notes:   Calls are serialised by the caller
`timescale 1ns/1ns
module cal_host_mdl
(
  input  wire logic        ref_clk_i,
  output logic      [7:0]  avs_address_o,
  output logic             avs_read_o,
  output logic             avs_write_o,
  output logic      [31:0] avs_writedata_o,
  input  wire logic [31:0] avs_readdata_i,
  input  wire logic        avs_waitrequest_i
);
  initial {avs_address_o, avs_read_o, avs_write_o, avs_writedata_o} = '0;
  // Request held until waitrequest is sampled low, data taken there
  task automatic acc(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk_i);
    avs_address_o <= adr;
    avs_read_o <= !wr;
    avs_write_o <= wr;
    avs_writedata_o <= wd;
    do @(posedge ref_clk_i); while (avs_waitrequest_i !== 1'b0);
    rd = avs_readdata_i;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
  endtask : acc
endmodule : cal_host_mdl

// file: verification/tb_cal_gauge.sv
// Purpose: Self-checking bench for cal_gauge
// Assumes: Cell resistance set to zero so full capacity equals qmax
// Notes:   Flag model tracks alerts and sticky events per update
`timescale 1ns/1ns
module tb_cal_gauge
  import cal_pkg::*;
;
  logic        clk, rst_n, mv, rd_s, wr_s, remaining_capacity_alert, terminate_discharge_alert, dsg, chg, irq, wq, m_rca, m_tda;
  logic [7:0]  adr, soc;
  logic [31:0] wd, rdat, q;
  logic [3:0]  m_stat;
  logic [15:0] cfg [14] = '{16'h0004, 16'h0005, 16'h0104, 16'h0105, 16'h0009, 16'h0000, 16'h0001, 16'h0002,
    16'h0003, 16'h0006, 16'h0100, 16'h0102, 16'h0106, 16'h0109};
  logic [15:0] exp_r [14] = '{16'h012C, 16'h0100, 16'h0456, 16'h0A00, 16'h0123, 16'h004D, 16'h0123, 16'h0096,
    16'h0000, 16'h00C8, 16'h0222, 16'h0258, 16'h01F4, 16'h0333};
  cal_meas_t   meas;
  int          errors, comparisons, set_p, m_filt;
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  cal_gauge DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .meas_valid_i(mv), .meas_i(meas), .avs_address_i(adr),
    .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .remaining_capacity_alert_o(remaining_capacity_alert),
    .terminate_discharge_alert_o(terminate_discharge_alert), .dsg_flow_o(dsg), .chg_flow_o(chg), .soc_o(soc), .irq_o(irq));
  cal_host_mdl h (.ref_clk_i(clk), .avs_address_o(adr), .avs_read_o(rd_s), .avs_write_o(wr_s),
    .avs_writedata_o(wd), .avs_readdata_i(rdat), .avs_waitrequest_i(wq));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results;
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // Seed capacity, send one update, then check against the model
  task automatic upd(input int cap, input int avg);
    int   s;
    logic r0, t0;
    h.acc(1'b1, ADR_CAP, cap, q);
    @(posedge clk);
    mv <= 1'b1;
    meas.avg_current <= avg[15:0];
    @(posedge clk);
    mv <= 1'b0;
    repeat (30) @(posedge clk);
    m_filt = m_filt + (avg - m_filt) / 14;  // Low-pass with 14 s time constant
    s = cap * 100 / 1500;
    r0 = m_rca;
    t0 = m_tda;
    if (cap < 100) m_rca = 1'b1;
    else if (cap > 100) m_rca = 1'b0;
    if (set_p != -1 && s < set_p) m_tda = 1'b1;
    else if (set_p != -1 && m_tda && s > 8) m_tda = 1'b0;
    m_stat = m_stat | {t0 & !m_tda, !t0 & m_tda, r0 & !m_rca, !r0 & m_rca};
    chk("rca", remaining_capacity_alert, m_rca);
    chk("tda", terminate_discharge_alert, m_tda);
    chk("soc", soc, s);
    chk("dsg", dsg, avg < -100);
    chk("chg", chg, avg > 50);
    chk("irq", irq, |m_stat);
  endtask : upd
  // Main sequence
  initial
  begin
    q = $urandom(24);
    {rst_n, mv, meas, m_rca, m_tda, m_stat} = '0;
    set_p = 6;
    m_filt = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("soc_rst", soc, 8'h64);
    h.acc(1'b0, ADR_CTRL, 32'h0000_0000, q);
    chk("ctrl_rst", q, 32'h0000_0001);
    h.acc(1'b1, ADR_CELL, 32'h0000_05DC, q);
    h.acc(1'b1, ADR_IRQ_MASK, 32'h0000_000F, q);
    h.acc(1'b1, ADR_HOST, 32'h0000_0100, q);
    upd(50, -150);
    upd(100, -101);
    upd(150, 51);
    upd(100, 50);
    h.acc(1'b1, ADR_TDA_PCT, 32'h0000_08FF, q);
    set_p = -1;
    upd(30, -100);
    h.acc(1'b1, ADR_TDA_PCT, 32'h0000_0806, q);
    set_p = 6;
    // Distinct source values so each numbered load select but 3 lands on its own rate; select 3's filtered current
    // reaches select 0's 0x4D, and the default select 9 repeats select 1's rate
    h.acc(1'b1, ADR_USR_RATE, 32'h0032_00C8, q);
    meas <= '{current: 16'h0000, voltage: 16'h0FA0, avg_current: 16'h0000, prev_avg_current: -16'sh004D,
      cycle_avg_current: 16'h0123, prev_avg_power: 16'h0222, cycle_avg_power: -16'sh0333};
    for (int i = 0; i < 14; i++)
    begin
      h.acc(1'b1, ADR_CTRL, {16'h0000, cfg[i]}, q);
      upd(500, -150);
      h.acc(1'b0, ADR_ENERGY, 32'h0000_0000, q);
      if (cfg[i] == 16'h0003)
        exp_r[i] = 16'(m_filt < 0 ? -m_filt : m_filt);
      chk("rate", q[31:16], exp_r[i]);
    end
    repeat (8) upd($urandom_range(1500), int'($urandom_range(600)) - 300);
    h.acc(1'b1, ADR_IRQ_STAT, 32'h0000_000F, q);
    m_stat = 4'h0;
    repeat (2) @(posedge clk);
    chk("irq_clr", irq, 1'b0);
    h.acc(1'b0, 8'h40, 32'h0000_0000, q);
    chk("unmapped", q, 32'h0000_0000);
    results();
  end
  // Watchdog
  initial
  begin
    #500000;
    errors++;
    results();
  end
endmodule : tb_cal_gauge
